/* logic/fwsr_ctrl.sv */
/*
 * Host controller that drives a parallel NOR flash through its chip, output and
 * write enable strobes and interprets its status bits during program and erase.
 * Assumes the flash data pins are resolved outside from o_dq and o_dq_oe, and that
 * the user issues one request at a time while o_busy is low.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_req_valid,
    input wire fwsr_pkg::fwsr_req_t i_req,
    output logic o_busy,
    output logic o_ans_valid,
    output fwsr_pkg::fwsr_ans_t o_ans,
    output logic o_ce_b,
    output logic o_oe_b,
    output logic o_we_b,
    output logic [fwsr_pkg::ADDR_W-1:0] o_addr,
    output logic [fwsr_pkg::DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic [fwsr_pkg::DATA_W-1:0] i_dq
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD, ST_RD_GAP, ST_EVAL, ST_RESET_CMD, ST_DONE
    } fwsr_state_t;

    fwsr_state_t state_r, state_nxt;
    fwsr_pkg::fwsr_op_t op_r;
    logic [fwsr_pkg::CNT_W-1:0] cnt_r;
    logic [fwsr_pkg::DATA_W-1:0] rd_r;
    logic [fwsr_pkg::DATA_W-1:0] prev_r;
    logic [1:0] nrd_r;
    logic tmo_seen_r;
    logic [fwsr_pkg::DATA_W-1:0] dq_sync;

    fwsr_sync #(.WIDTH(fwsr_pkg::DATA_W)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_dq),
        .o_sync(dq_sync)
    );

    // Status decode of the latest two reads.
    wire cnt_done = (cnt_r == fwsr_pkg::CNT_ZERO);
    wire tog_diff = rd_r[fwsr_pkg::BIT_TOGGLE] ^ prev_r[fwsr_pkg::BIT_TOGGLE];
    wire tmo_bit = rd_r[fwsr_pkg::BIT_TMO];
    wire win_bit = rd_r[fwsr_pkg::BIT_WIN];
    wire have_two = (nrd_r == 2'h2);
    wire is_poll = (op_r == fwsr_pkg::FWSR_OP_POLL);
    wire is_chkwin = (op_r == fwsr_pkg::FWSR_OP_CHKWIN);
    // Both a poll and a window check need two reads: the window bit means nothing
    // until a toggle shows that the erase command was taken.
    wire need_more = (is_poll || is_chkwin) && !have_two;
    // Toggle stopped means done; toggling with timeout seen twice means failure.
    wire poll_done = have_two && !tog_diff;
    wire poll_fail = have_two && tog_diff && tmo_seen_r && tmo_bit;
    wire is_write = (i_req.op == fwsr_pkg::FWSR_OP_WRITE);

    // Next-state selection.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (i_req_valid) begin
                    state_nxt = is_write ? ST_WR_LOW : ST_RD;
                end
            end
            ST_WR_LOW: begin
                if (cnt_done) begin
                    state_nxt = ST_WR_HIGH;
                end
            end
            ST_WR_HIGH: begin
                if (cnt_done) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_RD: begin
                if (cnt_done) begin
                    state_nxt = ST_RD_GAP;
                end
            end
            ST_RD_GAP: begin
                if (cnt_done) begin
                    state_nxt = ST_EVAL;
                end
            end
            ST_EVAL: begin
                if (need_more) begin
                    state_nxt = ST_RD;
                end else if (poll_fail) begin
                    state_nxt = ST_RESET_CMD;
                end else if (op_r == fwsr_pkg::FWSR_OP_POLL && !poll_done) begin
                    state_nxt = ST_RD;
                end else begin
                    state_nxt = ST_DONE;
                end
            end
            ST_RESET_CMD: begin
                state_nxt = ST_WR_LOW;
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register and strobe timer.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
            cnt_r <= fwsr_pkg::CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) begin
                cnt_r <= (state_nxt == ST_WR_LOW) ? fwsr_pkg::WP_CNT :
                         (state_nxt == ST_WR_HIGH) ? fwsr_pkg::WPH_CNT :
                         (state_nxt == ST_RD) ? fwsr_pkg::RD_CNT :
                         (state_nxt == ST_RD_GAP) ? fwsr_pkg::WPH_CNT : fwsr_pkg::CNT_ZERO;
            end else if (!cnt_done) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end

    // Request capture and read history; the status address is held for every read.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            op_r <= fwsr_pkg::FWSR_OP_READ;
            o_addr <= fwsr_pkg::ADDR_ZERO;
            o_dq <= fwsr_pkg::DATA_ZERO;
            rd_r <= fwsr_pkg::DATA_ZERO;
            prev_r <= fwsr_pkg::DATA_ZERO;
            nrd_r <= 2'h0;
            tmo_seen_r <= 1'b0;
        end else if (state_r == ST_IDLE && i_req_valid) begin
            op_r <= i_req.op;
            o_addr <= i_req.addr;
            o_dq <= i_req.data;
            nrd_r <= 2'h0;
            tmo_seen_r <= 1'b0;
        end else if (state_r == ST_RESET_CMD) begin
            o_dq <= fwsr_pkg::CMD_RESET;
        end else if (state_r == ST_RD && cnt_done) begin
            prev_r <= rd_r;
            rd_r <= dq_sync;
            nrd_r <= have_two ? 2'h2 : nrd_r + 2'h1;
        end else if (state_r == ST_EVAL && have_two) begin
            tmo_seen_r <= tog_diff && tmo_bit;
        end
    end

    // Bus strobes; data is driven only through a write pulse and its recovery.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_ce_b <= 1'b1;
            o_oe_b <= 1'b1;
            o_we_b <= 1'b1;
            o_dq_oe <= 1'b0;
        end else begin
            o_ce_b <= !(state_nxt == ST_WR_LOW || state_nxt == ST_RD);
            o_oe_b <= !(state_nxt == ST_RD);
            o_we_b <= !(state_nxt == ST_WR_LOW);
            o_dq_oe <= (state_nxt == ST_WR_LOW || state_nxt == ST_WR_HIGH);
        end
    end

    // Answer to the user, one cycle wide.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_busy <= 1'b0;
            o_ans_valid <= 1'b0;
            o_ans <= '0;
        end else begin
            o_busy <= (state_nxt != ST_IDLE);
            o_ans_valid <= (state_r == ST_DONE);
            if (state_r == ST_EVAL && !need_more) begin
                o_ans.data <= rd_r;
                if (op_r == fwsr_pkg::FWSR_OP_CHKWIN) begin
                    // No toggle means the command was never taken, so the check fails.
                    // The bit is always read, never skipped on command spacing.
                    // A one means the erase is running and no more sectors join.
                    o_ans.res <= !tog_diff ? fwsr_pkg::FWSR_RES_FAIL :
                                 win_bit ? fwsr_pkg::FWSR_RES_WIN_CLOSED :
                                 fwsr_pkg::FWSR_RES_WIN_OPEN;
                end else begin
                    o_ans.res <= poll_fail ? fwsr_pkg::FWSR_RES_FAIL : fwsr_pkg::FWSR_RES_OK;
                end
            end else if (state_r == ST_IDLE && i_req_valid && is_write) begin
                o_ans.res <= fwsr_pkg::FWSR_RES_OK;
            end
        end
    end

    AST_WE_OE_EXCL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !(!o_we_b && !o_oe_b)) else $error("write and output enable low together");
    AST_DQ_OE_NO_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !(o_dq_oe && !o_oe_b)) else $error("bus driven while flash outputs");
    AST_FAIL_RESETS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_EVAL && poll_fail) |=> state_r == ST_RESET_CMD ##1 !o_we_b)
        else $error("timeout failure not followed by reset command");
    AST_RESET_WORD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_RESET_CMD) |=> (o_dq == fwsr_pkg::CMD_RESET && o_dq_oe))
        else $error("reset command word not driven");
    AST_POLL_TWO_READS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_EVAL && op_r == fwsr_pkg::FWSR_OP_POLL && state_nxt == ST_DONE)
        |-> have_two) else $error("poll ended without two reads");
    AST_WIN_RESULT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_EVAL && is_chkwin && have_two && tog_diff) |=>
        ((o_ans.res == fwsr_pkg::FWSR_RES_WIN_CLOSED) == o_ans.data[fwsr_pkg::BIT_WIN]))
        else $error("window result disagrees with the window bit read");
    AST_WIN_UNTAKEN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_EVAL && is_chkwin && have_two && !tog_diff) |=>
        (o_ans.res == fwsr_pkg::FWSR_RES_FAIL)) else $error("window read without acceptance");
    AST_ANS_AFTER_DONE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_DONE) |=> o_ans_valid ##1 !o_ans_valid)
        else $error("answer not a single pulse after done");
    AST_WP_WIDTH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(o_we_b) |-> !o_we_b [*6]) else $error("write pulse too short");
    AST_FAIL_NEEDS_TMO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_r == ST_EVAL && poll_fail) |->
        (rd_r[fwsr_pkg::BIT_TMO] && prev_r[fwsr_pkg::BIT_TMO]))
        else $error("failure declared without timeout flag");
    COV_POLL_OK: cover property (@(posedge i_sys_clk)
        state_r == ST_EVAL && op_r == fwsr_pkg::FWSR_OP_POLL && poll_done);
    COV_POLL_FAIL: cover property (@(posedge i_sys_clk) state_r == ST_EVAL && poll_fail);
    COV_WIN_OPEN: cover property (@(posedge i_sys_clk)
        state_r == ST_EVAL && op_r == fwsr_pkg::FWSR_OP_CHKWIN && !win_bit);
    COV_WRITE: cover property (@(posedge i_sys_clk) $fell(o_we_b));
endmodule
`default_nettype wire

/* logic/fwsr_pkg.sv */
/*
 * Shared constants and types for the flash status controller: bus timing counts,
 * status bit positions, command codes and the user request/answer carriers.
 * Assumes a 100 MHz system clock and a 16-bit asynchronous flash data bus.
 */
package fwsr_pkg;
    localparam int SYS_CLK_MHZ = 100;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 18;
    // Bus strobe times in ns, with cycle counts rounded up.
    localparam int T_RD_NS = 90;
    localparam int T_WP_NS = 60;
    localparam int T_WPH_NS = 30;
    localparam int RD_CYC = (T_RD_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int WP_CYC = (T_WP_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int WPH_CYC = (T_WPH_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
    localparam logic [CNT_W-1:0] WP_CNT = CNT_W'(WP_CYC);
    localparam logic [CNT_W-1:0] WPH_CNT = CNT_W'(WPH_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    // Status bit positions on the data bus.
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_TMO = 5;
    localparam int BIT_WIN = 3;
    localparam int BIT_STOG = 2;
    // Reset command word, written to any address.
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    // User operations.
    typedef enum logic [1:0] {
        FWSR_OP_WRITE,
        FWSR_OP_READ,
        FWSR_OP_POLL,
        FWSR_OP_CHKWIN
    } fwsr_op_t;

    typedef struct packed {
        fwsr_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fwsr_req_t;

    // Result codes of a poll or window check.
    typedef enum logic [1:0] {
        FWSR_RES_OK,
        FWSR_RES_FAIL,
        FWSR_RES_WIN_OPEN,
        FWSR_RES_WIN_CLOSED
    } fwsr_res_t;

    typedef struct packed {
        fwsr_res_t res;
        logic [DATA_W-1:0] data;
    } fwsr_ans_t;
endpackage

/* logic/fwsr_sync.sv */
/*
 * Two flip-flop synchroniser for a bus of asynchronous flash data pins.
 * Assumes the input is stable long enough around each sample to be read twice.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_sync #(
    parameter int WIDTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* sim/fwsr_flash_model.sv */
/*
 * Behavioural flash model that answers the status controller's strobes.
 * Assumes the bench resolves the shared data bus and feeds it to i_dq.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model #(
    parameter int WIN_RD = 2,
    parameter int BUSY_RD = 4,
    parameter logic [15:0] SE_CMD = 16'h0030,
    parameter logic [15:0] CE_CMD = 16'h0010,
    parameter logic [15:0] BAD_CMD = 16'h00A0,
    parameter logic [15:0] ARRAY_WORD = 16'h5A5A
) (
    input wire logic i_ce_b,
    input wire logic i_oe_b,
    input wire logic i_we_b,
    input wire logic [17:0] i_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq
);
    logic erasing = 1'h0;
    logic failing = 1'h0;
    logic tog = 1'h0;
    logic stog = 1'h0;
    logic [7:0] sel = 8'h00;
    logic [15:0] word = 16'h0000;
    int win_cnt = 0;
    int run_cnt = 0;
    wire rd_b = i_ce_b | i_oe_b;
    wire wr_b = i_ce_b | i_we_b;
    wire shut = win_cnt >= WIN_RD;
    // A released bus shows the inverse of the last word, so a stale copy never passes.
    assign o_dq = rd_b ? ~word : word;
    // Commands latch on the rising write strobe.
    always @(posedge wr_b) begin
        if (i_dq === fwsr_pkg::CMD_RESET) begin
            failing = 1'h0;
        end else if (!failing && !(erasing && shut)) begin
            if (i_dq === SE_CMD) begin
                erasing = 1'h1;
                sel[i_addr[17:15]] = 1'h1;
                win_cnt = 0;
                run_cnt = 0;
            end else if (i_dq === CE_CMD) begin
                erasing = 1'h1;
                sel = 8'hFF;
                win_cnt = WIN_RD;
                run_cnt = 0;
            end else if (i_dq === BAD_CMD) begin
                failing = 1'h1;
            end
        end
    end
    // Each new read cycle advances the status bits; the window is timed in reads.
    always @(negedge rd_b) begin
        if (failing) begin
            tog = ~tog;
            word = {8'h00, 1'h0, tog, 1'h1, 5'h00};
        end else if (erasing) begin
            tog = ~tog;
            stog = sel[i_addr[17:15]] ? ~stog : stog;
            word = {8'h00, 1'h0, tog, 2'h0, shut, stog, 2'h0};
            run_cnt = shut ? run_cnt + 1 : run_cnt;
            win_cnt = shut ? win_cnt : win_cnt + 1;
            erasing = run_cnt <= BUSY_RD;
            sel = erasing ? sel : 8'h00;
        end else begin
            word = ARRAY_WORD;
        end
    end
endmodule
`default_nettype wire

/* sim/fwsr_ctrl_test.sv */
/*
 * Self-checking bench for the flash status controller.
 * Assumes the package and the flash model; expectations follow the model's parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module fwsr_ctrl_test;
    localparam logic [15:0] SE = 16'h0030;
    localparam logic [15:0] CHIP = 16'h0010;
    localparam logic [15:0] BAD = 16'h00A0;
    localparam logic [15:0] ARR = 16'h5A5A;
    // Four window reads let two back-to-back two-read window checks still see it open.
    localparam int WIN = 4;
    localparam fwsr_pkg::fwsr_op_t WR = fwsr_pkg::FWSR_OP_WRITE;
    localparam fwsr_pkg::fwsr_op_t RD = fwsr_pkg::FWSR_OP_READ;
    localparam fwsr_pkg::fwsr_op_t PL = fwsr_pkg::FWSR_OP_POLL;
    localparam fwsr_pkg::fwsr_op_t CW = fwsr_pkg::FWSR_OP_CHKWIN;
    localparam fwsr_pkg::fwsr_res_t OK = fwsr_pkg::FWSR_RES_OK;
    localparam fwsr_pkg::fwsr_res_t WO = fwsr_pkg::FWSR_RES_WIN_OPEN;
    localparam fwsr_pkg::fwsr_res_t WC = fwsr_pkg::FWSR_RES_WIN_CLOSED;
    typedef struct {
        fwsr_pkg::fwsr_op_t op;
        logic [17:0] addr;
        logic [15:0] data;
        fwsr_pkg::fwsr_res_t res;
        logic [15:0] mask;
        logic [15:0] exp;
    } fwsr_row_t;
    logic sys_clk = 1'h0;
    logic rst_b;
    logic req_valid;
    fwsr_pkg::fwsr_req_t req;
    logic busy, ans_valid, ce_b, oe_b, we_b, dq_oe;
    fwsr_pkg::fwsr_ans_t ans;
    logic [17:0] addr;
    logic [15:0] ctrl_dq, flash_dq;
    wire [15:0] bus = dq_oe ? ctrl_dq : flash_dq;
    int n_errors = 0;
    int n_compared = 0;
    fwsr_row_t rows[$];

    fwsr_ctrl dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_req_valid(req_valid), .i_req(req),
        .o_busy(busy), .o_ans_valid(ans_valid), .o_ans(ans), .o_ce_b(ce_b), .o_oe_b(oe_b),
        .o_we_b(we_b), .o_addr(addr), .o_dq(ctrl_dq), .o_dq_oe(dq_oe), .i_dq(bus));
    fwsr_flash_model #(.WIN_RD(WIN), .SE_CMD(SE), .CE_CMD(CHIP), .BAD_CMD(BAD),
        .ARRAY_WORD(ARR)) flash (
        .i_ce_b(ce_b), .i_oe_b(oe_b), .i_we_b(we_b), .i_addr(addr), .i_dq(bus), .o_dq(flash_dq));

    // The clock runs free at 100 MHz.
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // A hang is cut short well beyond the longest expected run.
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One request, then a bounded wait for its one-cycle answer pulse.
    task automatic run(input fwsr_pkg::fwsr_op_t op, input logic [17:0] a, input logic [15:0] d);
        int k;
        @(posedge sys_clk);
        req_valid <= 1'h1;
        req <= '{op, a, d};
        @(posedge sys_clk);
        req_valid <= 1'h0;
        for (k = 0; k < 3000 && ans_valid !== 1'h1; k++) begin
            @(posedge sys_clk);
        end
        check("answer pulse", {15'h0000, ans_valid}, 16'h0001);
    endtask

    task automatic add(fwsr_pkg::fwsr_op_t op, logic [17:0] a, logic [15:0] d,
        fwsr_pkg::fwsr_res_t r, logic [15:0] m, logic [15:0] e);
        fwsr_row_t w;
        w = '{op, a, d, r, m, e};
        rows.push_back(w);
    endtask

    // Main sequence: the row table first, then a refused request and a mid-run reset.
    initial begin
        int pulses;
        int wlow;
        rst_b = 1'h0;
        req_valid = 1'h0;
        req = '0;
        repeat (12) @(posedge sys_clk);
        check("reset strobes", {11'h000, busy, ce_b, oe_b, we_b, dq_oe}, 16'h000E);
        rst_b <= 1'h1;
        add(WR, 18'h00010, SE, OK, 16'h0000, 16'h0000);
        add(CW, 18'h00010, 16'h0000, WO, 16'h0088, 16'h0000);
        add(WR, 18'h08000, SE, OK, 16'h0000, 16'h0000);
        add(CW, 18'h08000, 16'h0000, WO, 16'h0088, 16'h0000);
        add(CW, 18'h08000, 16'h0000, WO, 16'h0088, 16'h0000);
        add(CW, 18'h00010, 16'h0000, WC, 16'h0088, 16'h0008);
        add(WR, 18'h00010, SE, OK, 16'h0000, 16'h0000);
        add(CW, 18'h00010, 16'h0000, WC, 16'h0088, 16'h0008);
        add(PL, 18'h00010, 16'h0000, OK, 16'hFFFF, ARR);
        add(WR, 18'h10000, CHIP, OK, 16'h0000, 16'h0000);
        add(CW, 18'h10000, 16'h0000, WC, 16'h0088, 16'h0008);
        add(PL, 18'h10000, 16'h0000, OK, 16'hFFFF, ARR);
        add(WR, 18'h10000, BAD, OK, 16'h0000, 16'h0000);
        add(PL, 18'h10000, 16'h0000, fwsr_pkg::FWSR_RES_FAIL, 16'h0020, 16'h0020);
        add(RD, 18'h10000, 16'h0000, OK, 16'hFFFF, ARR);
        add(CW, 18'h00010, 16'h0000, fwsr_pkg::FWSR_RES_FAIL, 16'hFFFF, ARR);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].addr, rows[i].data);
            check("result", {14'h0000, ans.res}, {14'h0000, rows[i].res});
            check("status", ans.data & rows[i].mask, rows[i].exp);
            $display("row %0d done", i);
        end
        // A request raised while busy must vanish without any write strobe.
        @(posedge sys_clk);
        req_valid <= 1'h1;
        req <= '{RD, 18'h00010, 16'h0000};
        @(posedge sys_clk);
        req <= '{WR, 18'h00010, BAD};
        pulses = 0;
        wlow = 0;
        repeat (40) begin
            @(posedge sys_clk);
            req_valid <= 1'h0;
            pulses += int'(ans_valid === 1'h1);
            wlow += int'(we_b !== 1'h1);
        end
        check("pulses", 16'(pulses), 16'h0001);
        check("write strobes", 16'(wlow), 16'h0000);
        check("read data", ans.data, ARR);
        $display("busy refusal test done");
        // A reset in mid-read returns every strobe to idle.
        run(RD, 18'h00010, 16'h0000);
        @(posedge sys_clk);
        req_valid <= 1'h1;
        @(posedge sys_clk);
        req_valid <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'h0;
        repeat (3) @(posedge sys_clk);
        check("mid reset", {11'h000, busy, ce_b, oe_b, we_b, dq_oe}, 16'h000E);
        rst_b <= 1'h1;
        run(RD, 18'h00010, 16'h0000);
        check("read after reset", ans.data, ARR);
        $display("reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
